// ==== inc/eds_paging_defines.svh ====
// timing counts and address constants for the paging and stack guard
// assumes inclusion by bare name from inc/
`ifndef EDS_PAGING_DEFINES_SVH
`define EDS_PAGING_DEFINES_SVH
`define NEAR_LIMIT 16'h8000
`define SFR_FLOOR 16'h0800
`define EXT_READ_CYCLES 2
`define REP_FIRST_CYCLES 3
`define REP_SLOW_COUNT 2
`define WRITE_CYCLES 1
`define PSV_BIT 9
`endif

// ==== inc/eds_paging_pkg.sv ====
// types for the paging and stack guard
// assumes nothing beyond the defines header
package eds_paging_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_WAIT = 3'b010,
      ST_DONE = 3'b100
   } acc_state_t;
   typedef enum logic [1:0] {
      SPACE_NEAR = 2'h0,
      SPACE_EXT = 2'h1,
      SPACE_PROG = 2'h2
   } space_t;
endpackage : eds_paging_pkg

// ==== core/stack_guard.sv ====
// stack limit register and overflow/underflow checks
// assumes the caller qualifies stack accesses
`timescale 1ns/10ps
`include "eds_paging_defines.svh"
module stack_guard (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic limit_we_i,
   input wire logic [15:0] limit_wdata_i,
   input wire logic stack_acc_i,
   input wire logic stack_push_i,
   input wire logic [15:0] stack_ea_i,
   output logic [15:0] limit_o,
   output logic stack_fault_o
);
   // no reset, bit 0 forced low
   logic [15:0] limit_r;
   always_ff @(posedge ref_clk_i) begin
      if (limit_we_i) begin
         limit_r <= {limit_wdata_i[15:1], 1'b0};
      end
   end
   assign limit_o = limit_r;
   wire over_w = stack_acc_i && stack_push_i && (stack_ea_i > limit_r);
   wire under_w = stack_acc_i && (stack_ea_i < `SFR_FLOOR);
   assign stack_fault_o = over_w || under_w;
endmodule : stack_guard

// ==== core/eds_paging_and_stack_guard.sv ====
// data-space address generation with page windows and stack traps
// assumes the cpu holds a request until done_o and keeps
`timescale 1ns/10ps
`include "eds_paging_defines.svh"
module eds_paging_and_stack_guard (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic [9:0] read_page_select_i,
   input wire logic [8:0] write_page_select_i,
   input wire logic req_i,
   input wire logic write_i,
   input wire logic repeat_i,
   input wire logic [15:0] ea_i,
   input wire logic stack_i,
   input wire logic push_i,
   input wire logic [15:0] stack_pointer_word_i,
   input wire logic call_push_i,
   input wire logic exc_push_i,
   input wire logic [7:0] pc_high_i,
   input wire logic [7:0] status_low_byte_i,
   input wire logic limit_we_i,
   input wire logic [15:0] limit_wdata_i,
   output logic [23:0] mem_addr_o,
   output logic [1:0] mem_space_o,
   output logic mem_rd_o,
   output logic mem_wr_o,
   output logic done_o,
   output logic addr_trap_o,
   output logic stack_trap_o,
   output logic [15:0] soft_stack_pointer_o,
   output logic [7:0] push_high_byte_o,
   output logic [15:0] stack_limit_value_o
);
   import eds_paging_pkg::*;

   // ********************************
   // address decode
   // ********************************
   wire [15:0] acc_ea_w = stack_i ? (push_i ? stack_pointer_word_i
                                    : stack_pointer_word_i - 16'h0002) : ea_i;
   wire in_win_w = acc_ea_w[15];
   // program view flag is bit 9
   wire psv_w = !write_i && read_page_select_i[`PSV_BIT];
   wire page_zero_w = in_win_w && (write_i ? (write_page_select_i == 9'h000)
                                   : (read_page_select_i == 10'h000));
   // address forming, page is 32 Kbytes
   wire [23:0] near_addr_w = {8'h00, acc_ea_w};
   wire [23:0] rd_addr_w = psv_w ? {1'b0, read_page_select_i[7:0], acc_ea_w[14:0]}
                                 : {read_page_select_i[8:0], acc_ea_w[14:0]};
   wire [23:0] wr_addr_w = {write_page_select_i, acc_ea_w[14:0]};
   // pages only come from the inputs
   wire [23:0] addr_w = !in_win_w ? near_addr_w : (write_i ? wr_addr_w : rd_addr_w);
   wire [1:0] space_w = !in_win_w ? SPACE_NEAR : (psv_w ? SPACE_PROG : SPACE_EXT);
   wire ext_read_w = in_win_w && !write_i;

   logic stack_fault_w;
   logic [15:0] limit_w;
   stack_guard u_guard (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .limit_we_i(limit_we_i),
      .limit_wdata_i(limit_wdata_i),
      .stack_acc_i(req_i && stack_i),
      .stack_push_i(push_i),
      .stack_ea_i(acc_ea_w),
      .limit_o(limit_w),
      .stack_fault_o(stack_fault_w)
   );

   // ********************************
   // access sequencing
   // ********************************
   acc_state_t state_r, state_nxt;
   logic [1:0] wait_r, wait_nxt;
   logic [1:0] rep_cnt_r;
   wire [1:0] extra_w = !ext_read_w ? 2'h0 :
                        (repeat_i ? ((rep_cnt_r < `REP_SLOW_COUNT) ?
                         2'(`REP_FIRST_CYCLES - 1) : 2'h0) : 2'(`EXT_READ_CYCLES - 1));
   wire fault_w = page_zero_w || stack_fault_w;
   wire start_w = (state_r == ST_IDLE) && req_i;

   always_comb begin
      state_nxt = state_r;
      wait_nxt = wait_r;
      case (state_r)
         ST_IDLE: begin
            // writes and near reads finish now
            if (req_i && !fault_w && extra_w != 2'h0) begin
               state_nxt = ST_WAIT;
               wait_nxt = extra_w - 2'h1;
            end
         end
         ST_WAIT: begin
            if (wait_r == 2'h0) begin
               state_nxt = ST_IDLE;
            end else begin
               wait_nxt = wait_r - 2'h1;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   wire fin_w = (start_w && (fault_w || extra_w == 2'h0)) ||
                (state_r == ST_WAIT && wait_r == 2'h0);

   logic [15:0] ssp_r;
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_r <= ST_IDLE;
         wait_r <= 2'h0;
         rep_cnt_r <= 2'h0;
         mem_addr_o <= 24'h000000;
         mem_space_o <= 2'h0;
         mem_rd_o <= 1'b0;
         mem_wr_o <= 1'b0;
         done_o <= 1'b0;
         addr_trap_o <= 1'b0;
         stack_trap_o <= 1'b0;
         ssp_r <= 16'h0000;
         push_high_byte_o <= 8'h00;
      end else begin
         state_r <= state_nxt;
         wait_r <= wait_nxt;
         done_o <= fin_w;
         addr_trap_o <= start_w && page_zero_w;
         stack_trap_o <= start_w && stack_fault_w;
         mem_rd_o <= start_w && !fault_w && !write_i;
         mem_wr_o <= start_w && !fault_w && write_i;
         if (start_w) begin
            mem_addr_o <= addr_w;
            mem_space_o <= space_w;
         end
         if (!repeat_i) begin
            rep_cnt_r <= 2'h0;
         end else if (start_w && ext_read_w && !fault_w && rep_cnt_r < `REP_SLOW_COUNT) begin
            rep_cnt_r <= rep_cnt_r + 2'h1;
         end
         if (start_w && stack_i && !fault_w) begin
            ssp_r <= push_i ? stack_pointer_word_i + 16'h0002 : acc_ea_w;
         end
         if (call_push_i) begin
            push_high_byte_o <= 8'h00;
         end else if (exc_push_i) begin
            push_high_byte_o <= status_low_byte_i;
         end
      end
   end
   assign soft_stack_pointer_o = ssp_r;
   assign stack_limit_value_o = limit_w;

   // ********************************
   // checks
   // ********************************
   property p_page_zero;
      @(posedge ref_clk_i) disable iff (rst_i)
      start_w && page_zero_w |=> addr_trap_o && !mem_rd_o && !mem_wr_o;
   endproperty
   a_page_zero: assert property (p_page_zero) else $error("page zero no trap");
   property p_write_one;
      @(posedge ref_clk_i) disable iff (rst_i)
      start_w && write_i && !fault_w |=> done_o && mem_wr_o;
   endproperty
   a_write_one: assert property (p_write_one) else $error("write slow");
   property p_read_two;
      @(posedge ref_clk_i) disable iff (rst_i)
      start_w && ext_read_w && !repeat_i && !fault_w |=> !done_o ##1 done_o;
   endproperty
   a_read_two: assert property (p_read_two) else $error("read not two");
   property p_near;
      @(posedge ref_clk_i) disable iff (rst_i)
      start_w && !in_win_w |=> mem_addr_o == {8'h00, $past(acc_ea_w)};
   endproperty
   a_near: assert property (p_near) else $error("near map wrong");
   property p_wr_addr;
      @(posedge ref_clk_i) disable iff (rst_i)
      start_w && write_i && in_win_w |=> mem_addr_o[23:15] == $past(write_page_select_i);
   endproperty
   a_wr_addr: assert property (p_wr_addr) else $error("write page wrong");
   property p_psv;
      @(posedge ref_clk_i) disable iff (rst_i)
      start_w && psv_w && in_win_w |=> mem_space_o == SPACE_PROG && !mem_addr_o[23];
   endproperty
   a_psv: assert property (p_psv) else $error("program view wrong");
   property p_under;
      @(posedge ref_clk_i) disable iff (rst_i)
      start_w && stack_i && acc_ea_w < `SFR_FLOOR |=> stack_trap_o;
   endproperty
   a_under: assert property (p_under) else $error("underflow missed");
   property p_trap_pulse;
      @(posedge ref_clk_i) disable iff (rst_i)
      addr_trap_o |=> !addr_trap_o;
   endproperty
   a_trap_pulse: assert property (p_trap_pulse) else $error("trap not pulse");
   property p_limit_eq;
      @(posedge ref_clk_i) disable iff (rst_i)
      start_w && stack_i && push_i && acc_ea_w == limit_w &&
      acc_ea_w >= `SFR_FLOOR |=> !stack_trap_o;
   endproperty
   a_limit_eq: assert property (p_limit_eq) else $error("equal push trapped");
   property p_call;
      @(posedge ref_clk_i) disable iff (rst_i)
      call_push_i |=> push_high_byte_o == 8'h00;
   endproperty
   a_call: assert property (p_call) else $error("call byte not clear");
   c_ext_read: cover property (@(posedge ref_clk_i) start_w && ext_read_w && !fault_w);
   c_rep: cover property (@(posedge ref_clk_i) start_w && repeat_i && ext_read_w);
   c_strap: cover property (@(posedge ref_clk_i) stack_trap_o);
endmodule : eds_paging_and_stack_guard

// ==== tb/cpu_partner.sv ====
// cpu side model: raises a request and holds it until the access completes
// assumes the bench pulses go_i for one cycle and the design answers with done_i
`timescale 1ns/10ps
module cpu_partner (
   input wire logic ref_clk_i,
   input wire logic go_i,
   input wire logic done_i,
   output logic req_o
);
   logic go_seen;
   initial begin
      req_o = 1'b0;
   end
   // no rmw, bit 15 set, no read after limit write
   always @(posedge ref_clk_i) begin
      go_seen = go_i;
      #1;
      if (done_i === 1'b1) begin
         req_o = 1'b0;
      end
      if (go_seen === 1'b1) begin
         req_o = 1'b1;
      end
   end
endmodule : cpu_partner

// ==== tb/eds_paging_and_stack_guard_bench.sv ====
// self-checking bench for the paging and stack guard block
// assumes the package from inc/ and the cpu partner from tb/
`timescale 1ns/10ps
module eds_paging_and_stack_guard_bench;
   import eds_paging_pkg::*;
   logic ref_clk_i, rst_i, req, go, wr, rep, stk, psh, cp, ep, lwe;
   logic mrd, mwr, done, atr, str, a_rd, a_wr, a_at, a_st, e_at, e_st;
   logic [9:0] rpg;
   logic [8:0] wpg;
   logic [15:0] ea, sp, lwd, lim, soft_stack_pointer, slv;
   logic [7:0] pch, slb, phb;
   logic [23:0] mad, e_ad;
   logic [1:0] msp, e_sp;
   logic [31:0] lfsr;
   int n_mismatch, compares, rcnt, el, i;
   eds_paging_and_stack_guard dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .read_page_select_i(rpg), .write_page_select_i(wpg), .req_i(req), .write_i(wr),
      .repeat_i(rep), .ea_i(ea), .stack_i(stk), .push_i(psh), .stack_pointer_word_i(sp),
      .call_push_i(cp), .exc_push_i(ep), .pc_high_i(pch), .status_low_byte_i(slb),
      .limit_we_i(lwe), .limit_wdata_i(lwd), .mem_addr_o(mad), .mem_space_o(msp),
      .mem_rd_o(mrd), .mem_wr_o(mwr), .done_o(done), .addr_trap_o(atr), .stack_trap_o(str),
      .soft_stack_pointer_o(soft_stack_pointer), .push_high_byte_o(phb), .stack_limit_value_o(slv));
   cpu_partner part_u (.ref_clk_i(ref_clk_i), .go_i(go), .done_i(done), .req_o(req));
   initial begin
      ref_clk_i = 1'b0;
      forever #20 ref_clk_i = ~ref_clk_i;
   end
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr_next
   task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic summarize;
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : summarize
   task automatic step;
      @(posedge ref_clk_i);
      #1;
   endtask : step
   // ***************************
   // one access with model check
   // ***************************
   task automatic access(input logic w, s, p, input logic [15:0] a, s0);
      int k;
      logic [15:0] sa;
      logic xt;
      wr = w;
      stk = s;
      psh = p;
      ea = a;
      sp = s0;
      go = 1'b1;
      sa = p ? s0 : s0 - 16'h0002;
      xt = !s && a[15];
      e_at = xt && (w ? (wpg == 9'h000) : (rpg == 10'h000));
      e_st = s && ((p && sa > lim) || sa < 16'h0800);
      e_ad = s ? {8'h00, sa} : !a[15] ? {8'h00, a} : w ? {wpg, a[14:0]} :
         rpg[9] ? {1'b0, rpg[7:0], a[14:0]} : {rpg[8:0], a[14:0]};
      e_sp = !xt ? SPACE_NEAR : (!w && rpg[9]) ? SPACE_PROG : SPACE_EXT;
      el = (e_at || e_st || w || !xt) ? 1 : rep ? ((rcnt < 2) ? 3 : 1) : 2;
      if (xt && !w && !e_at && rep) rcnt++;
      if (!rep) rcnt = 0;
      step();
      go = 1'b0;
      {a_rd, a_wr, a_at, a_st} = 4'h0;
      k = 0;
      while (k < 20 && done !== 1'b1) begin
         step();
         k++;
         a_rd |= mrd;
         a_wr |= mwr;
         a_at |= atr;
         a_st |= str;
      end
      if (k == 20) begin
         n_mismatch++;
         summarize();
      end
      chk("latency", el, k);
      chk("addr_trap", e_at, a_at);
      chk("stack_trap", e_st, a_st);
      chk("mem_rd", !w && !e_at && !e_st, a_rd);
      chk("mem_wr", w && !e_at && !e_st, a_wr);
      if (!e_at && !e_st) begin
         chk("mem_addr", e_ad, mad);
         chk("mem_space", e_sp, msp);
         if (s) chk("stack_ptr", p ? s0 + 16'h0002 : s0 - 16'h0002, soft_stack_pointer);
      end
   endtask : access
   initial begin
      {go, wr, rep, stk, psh, cp, ep, lwe} = 8'h00;
      rpg = 10'h001;
      wpg = 9'h001;
      ea = 16'h0000;
      sp = 16'h0800;
      lwd = 16'h0000;
      pch = 8'hFF;
      slb = 8'h00;
      lfsr = 32'h0F73;
      n_mismatch = 0;
      compares = 0;
      rcnt = 0;
      rst_i = 1'b1;
      repeat (12) @(posedge ref_clk_i);
      #1;
      rst_i = 1'b0;
      lwd = 16'h1FFF;
      lwe = 1'b1;
      step();
      lwe = 1'b0;
      lim = 16'h1FFE;
      step();
      chk("limit", lim, slv);
      access(1'b1, 1'b1, 1'b1, 16'h0000, 16'h1FFE);
      access(1'b1, 1'b1, 1'b1, 16'h0000, 16'h2000);
      access(1'b0, 1'b1, 1'b0, 16'h0000, 16'h0802);
      access(1'b0, 1'b1, 1'b0, 16'h0000, 16'h0800);
      // exception first so the later call clear is visible
      lfsr = lfsr_next(lfsr);
      slb = lfsr[7:0] | 8'h01;
      pch = lfsr[15:8] | 8'h01;
      ep = 1'b1;
      step();
      ep = 1'b0;
      step();
      chk("push_byte", slb, phb);
      cp = 1'b1;
      step();
      cp = 1'b0;
      step();
      chk("push_byte", 24'h0, phb);
      rpg = 10'h000;
      wpg = 9'h000;
      access(1'b0, 1'b0, 1'b0, 16'h8000, 16'h0800);
      access(1'b1, 1'b0, 1'b0, 16'hFFFE, 16'h0800);
      access(1'b0, 1'b0, 1'b0, 16'h7FFE, 16'h0800);
      for (i = 0; i < 24; i++) begin
         lfsr = lfsr_next(lfsr);
         rpg = lfsr[25:16];
         wpg = lfsr[24:16];
         access(lfsr[31], 1'b0, 1'b0, lfsr[15:0], 16'h0800);
      end
      rep = 1'b1;
      rpg = 10'h002;
      for (i = 0; i < 4; i++) access(1'b0, 1'b0, 1'b0, 16'hFFFE, 16'h0800);
      rep = 1'b0;
      summarize();
   end
endmodule : eds_paging_and_stack_guard_bench
